// [rtl/mat_mem.sv]
`timescale 1ns/1ps
`default_nettype none
// small two-address table memory, registered read data
module mat_mem #(
    parameter int DEPTH = 64,
    parameter int W = 72,
    parameter int AW = 6
) (
    input wire logic clock,            // system clock
    input wire logic we,               // write strobe
    input wire logic [AW-1:0] addr,    // word address
    input wire logic [AW-1:0] waddr,   // write address
    input wire logic [W-1:0] wdata,    // write data
    output logic [W-1:0] rdata         // read data, one cycle later
);
    logic [W-1:0] mem [DEPTH];
    // ----------------------------------------
    // storage
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule : mat_mem
`default_nettype wire

// [rtl/mat_pkg.sv]
package mat_pkg;
    // ----------------------------------------
    // widths
    // ----------------------------------------
    localparam int MAC_W = 48;
    localparam int VLAN_W = 12;
    localparam int IF_W = 6;      // bit 5 = trunk, low bits = port/trunk number
    localparam int AGE_W = 12;
    localparam int ENT_W = 1 + 1 + 1 + 1 + IF_W + VLAN_W + MAC_W;
    // ----------------------------------------
    // aging
    // ----------------------------------------
    localparam logic [AGE_W-1:0] AGE_MIN_S = 12'h011;  // 17 s
    localparam logic [AGE_W-1:0] AGE_MAX_S = 12'h888;  // 2184 s
    localparam logic [AGE_W-1:0] AGE_DEF_S = 12'h12C;  // 300 s
    localparam longint CLK_HZ = 20000000;
    localparam int SEC_CYCLES = int'(CLK_HZ);
    // ----------------------------------------
    // management commands
    // ----------------------------------------
    typedef enum logic [2:0] {
        MAT_CMD_ADD_STATIC = 3'h0,
        MAT_CMD_DEL_STATIC = 3'h1,
        MAT_CMD_SET_AGE = 3'h2,
        MAT_CMD_QUERY = 3'h3,
        MAT_CMD_NOP = 3'h7
    } mat_cmd_e;
    typedef enum logic [1:0] {
        MAT_QRY_IF = 2'h0,
        MAT_QRY_MAC = 2'h1,
        MAT_QRY_VLAN = 2'h2,
        MAT_QRY_ALL = 2'h3
    } mat_qry_e;
endpackage : mat_pkg

// [rtl/mat_table.sv]
`timescale 1ns/1ps
`default_nettype none
// How it works
// - a frame's source MAC, VLAN and interface is learned as a dynamic entry unless it hits a static entry or the table is full
// - known destination forwards only to the entry's interface
// - unknown destination floods the frame to all ports
// - static entries stay on their interface; learning never moves them
// - static source on another interface is ignored, table untouched
// - aging time 17 to 2184 s, 300 s after reset
// - static entry carries keep-over-reset or delete-on-reset attribute
// - static entry built from interface (port or trunk), MAC and VLAN
// - dynamic entries searched by interface, MAC or VLAN
module mat_table
    import mat_pkg::*;
#(
    parameter int DEPTH = 64,
    parameter int AW = 6,
    parameter int SEC_CYC = SEC_CYCLES
) (
    input wire logic clock,                  // system clock
    input wire logic resetn,                 // synchronous reset, active low
    input wire logic frm_valid,              // frame header presented
    input wire logic [MAC_W-1:0] frm_sa,     // source MAC
    input wire logic [MAC_W-1:0] frm_da,     // destination MAC
    input wire logic [VLAN_W-1:0] frm_vlan,  // VLAN id
    input wire logic [IF_W-1:0] frm_if,      // ingress interface
    output logic frm_ready,                  // table idle, header taken
    output logic fwd_valid,                  // forwarding decision pulse
    output logic fwd_flood,                  // flood to all ports
    output logic [IF_W-1:0] fwd_if,          // egress interface
    input wire logic mg_valid,               // management command
    input wire logic [2:0] mg_cmd,           // command code
    input wire logic [1:0] mg_qsel,          // query filter
    input wire logic [MAC_W-1:0] mg_mac,     // MAC operand
    input wire logic [VLAN_W-1:0] mg_vlan,   // VLAN operand
    input wire logic [IF_W-1:0] mg_if,       // interface operand
    input wire logic mg_keep,                // static persists across reset
    input wire logic [AGE_W-1:0] mg_age,     // aging time in seconds
    output logic mg_ready,                   // command taken
    output logic mg_done,                    // command finished pulse
    output logic mg_err,                     // bad argument or table full
    output logic qr_valid,                   // query result pulse
    output logic [MAC_W-1:0] qr_mac,         // result MAC
    output logic [VLAN_W-1:0] qr_vlan,       // result VLAN
    output logic [IF_W-1:0] qr_if,           // result interface
    output logic [AGE_W-1:0] age_time        // current aging time
);
    // entry: valid, static, keep, hit, if, vlan, mac
    typedef enum logic [2:0] {
        ST_INIT = 3'h0,
        ST_IDLE = 3'h1,
        ST_SCAN = 3'h2,
        ST_DONE = 3'h3
    } mat_st_e;
    typedef enum logic [1:0] {
        OP_FRAME = 2'h0,
        OP_MGMT = 2'h1,
        OP_AGE = 2'h2,
        OP_CLEAR = 2'h3
    } mat_op_e;

    mat_st_e st_r, st_nxt;
    mat_op_e op_r, op_nxt;
    logic [AW:0] idx_r, idx_nxt;
    logic [AW-1:0] free_r, free_nxt, hit_r, hit_nxt;
    logic fnd_free_r, fnd_free_nxt, fnd_sa_r, fnd_sa_nxt, fnd_da_r, fnd_da_nxt;
    logic [MAC_W-1:0] sa_r, sa_nxt, dam_r, dam_nxt;
    logic [VLAN_W-1:0] vl_r, vl_nxt;
    logic [IF_W-1:0] if_r, if_nxt;
    logic [2:0] cmd_r, cmd_nxt;
    logic [1:0] qs_r, qs_nxt;
    logic keep_r, keep_nxt, age_req_r, age_req_nxt;
    logic [AGE_W-1:0] age_r, age_nxt, sec_left_r, sec_left_nxt;
    logic [31:0] tick_r, tick_nxt;
    logic frdy_r, frdy_nxt, fv_r, fv_nxt, ffl_r, ffl_nxt;
    logic [IF_W-1:0] fif_r, fif_nxt;
    logic mrdy_r, mrdy_nxt, md_r, md_nxt, me_r, me_nxt, qv_r, qv_nxt;
    logic [MAC_W-1:0] qm_r, qm_nxt;
    logic [VLAN_W-1:0] qvl_r, qvl_nxt;
    logic [IF_W-1:0] qif_r, qif_nxt;
    logic we;
    logic [AW-1:0] maddr;
    logic [ENT_W-1:0] wdata, rdata;
    logic e_v, e_st, e_keep, e_hit;
    logic [IF_W-1:0] e_if;
    logic [VLAN_W-1:0] e_vl;
    logic [MAC_W-1:0] e_mac;
    logic rd_ok;
    logic [AW-1:0] rix;

    function automatic logic [ENT_W-1:0] pack(input logic v, input logic s, input logic k,
        input logic h, input logic [IF_W-1:0] i, input logic [VLAN_W-1:0] vl,
        input logic [MAC_W-1:0] m);
        pack = {v, s, k, h, i, vl, m};
    endfunction : pack

    assign {e_v, e_st, e_keep, e_hit, e_if, e_vl, e_mac} = rdata;
    // entry idx_r-1 is on rdata while scanning
    assign rd_ok = (st_r == ST_SCAN) && (idx_r != '0);
    assign rix = AW'(idx_r - (AW+1)'(1));

    mat_mem #(.DEPTH(DEPTH), .W(ENT_W), .AW(AW)) u_mem (
        .clock(clock),
        .we(we),
        .addr(idx_r[AW-1:0]),
        .waddr(maddr),
        .wdata(wdata),
        .rdata(rdata)
    );

    // ----------------------------------------
    // aging timer: one-second tick, then seconds count down
    // ----------------------------------------
    always_comb begin
        tick_nxt = tick_r + 32'h1;
        sec_left_nxt = sec_left_r;
        age_req_nxt = age_req_r;
        if (st_r == ST_IDLE && !(mg_valid && !mrdy_r)) begin
            age_req_nxt = 1'b0;
        end
        if (tick_r >= 32'(SEC_CYC - 1)) begin
            tick_nxt = '0;
            if (sec_left_r <= 12'h001) begin
                sec_left_nxt = age_r;
                age_req_nxt = 1'b1;
            end else begin
                sec_left_nxt = sec_left_r - 12'h001;
            end
        end
        if (age_nxt != age_r) begin
            sec_left_nxt = age_nxt;
        end
    end

    // ----------------------------------------
    // main sequencer: every operation but MAT_CMD_SET_AGE scans the whole table
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r; op_nxt = op_r; idx_nxt = idx_r;
        free_nxt = free_r; hit_nxt = hit_r;
        fnd_free_nxt = fnd_free_r; fnd_sa_nxt = fnd_sa_r; fnd_da_nxt = fnd_da_r;
        sa_nxt = sa_r; dam_nxt = dam_r; vl_nxt = vl_r; if_nxt = if_r;
        cmd_nxt = cmd_r; qs_nxt = qs_r; keep_nxt = keep_r; age_nxt = age_r;
        frdy_nxt = 1'b0; fv_nxt = 1'b0; ffl_nxt = ffl_r; fif_nxt = fif_r;
        mrdy_nxt = 1'b0; md_nxt = 1'b0; me_nxt = 1'b0; qv_nxt = 1'b0;
        qm_nxt = qm_r; qvl_nxt = qvl_r; qif_nxt = qif_r;
        we = 1'b0;
        maddr = idx_r[AW-1:0];
        wdata = '0;
        case (st_r)
            ST_INIT: begin
                op_nxt = OP_CLEAR; idx_nxt = '0; st_nxt = ST_SCAN;
            end
            ST_IDLE: begin
                idx_nxt = '0; fnd_free_nxt = 1'b0; fnd_sa_nxt = 1'b0; fnd_da_nxt = 1'b0;
                if (mg_valid && !mrdy_r) begin
                    cmd_nxt = mg_cmd; qs_nxt = mg_qsel; sa_nxt = mg_mac; vl_nxt = mg_vlan;
                    if_nxt = mg_if; keep_nxt = mg_keep; mrdy_nxt = 1'b1;
                    if (mg_cmd == MAT_CMD_SET_AGE) begin
                        if (mg_age >= AGE_MIN_S && mg_age <= AGE_MAX_S) begin
                            age_nxt = mg_age;
                        end else begin
                            me_nxt = 1'b1;
                        end
                        md_nxt = 1'b1;
                    end else begin
                        op_nxt = OP_MGMT; st_nxt = ST_SCAN;
                    end
                end else if (age_req_r) begin
                    op_nxt = OP_AGE; st_nxt = ST_SCAN;
                end else if (frm_valid && !frdy_r) begin
                    sa_nxt = frm_sa; dam_nxt = frm_da; vl_nxt = frm_vlan; if_nxt = frm_if;
                    frdy_nxt = 1'b1; op_nxt = OP_FRAME; st_nxt = ST_SCAN;
                end
            end
            ST_SCAN: begin
                if (idx_r < (AW+1)'(DEPTH)) begin
                    idx_nxt = idx_r + (AW+1)'(1);
                end
                if (rd_ok) begin
                    case (op_r)
                        OP_CLEAR: begin
                            // statics marked keep survive reset, all else cleared
                            we = 1'b1;
                            maddr = rix;
                            if (e_v && e_st && e_keep) begin
                                wdata = rdata;
                            end
                        end
                        OP_AGE: begin
                            if (e_v && !e_st) begin
                                we = 1'b1;
                                maddr = rix;
                                // not seen since last sweep: remove
                                wdata = e_hit ? pack(1'b1, 1'b0, 1'b0, 1'b0, e_if, e_vl, e_mac)
                                              : '0;
                            end
                        end
                        OP_FRAME: begin
                            if (e_v && e_mac == dam_r && e_vl == vl_r && !fnd_da_r) begin
                                fnd_da_nxt = 1'b1; fif_nxt = e_if;
                            end
                            if (e_v && e_mac == sa_r && e_vl == vl_r) begin
                                fnd_sa_nxt = 1'b1; hit_nxt = rix;
                                ffl_nxt = e_st;
                            end
                        end
                        default: begin
                            if (cmd_r == MAT_CMD_QUERY) begin
                                if (e_v && !e_st && ((qs_r == MAT_QRY_IF && e_if == if_r) ||
                                    (qs_r == MAT_QRY_MAC && e_mac == sa_r) ||
                                    (qs_r == MAT_QRY_VLAN && e_vl == vl_r) ||
                                    qs_r == MAT_QRY_ALL)) begin
                                    qv_nxt = 1'b1;
                                    qm_nxt = e_mac; qvl_nxt = e_vl; qif_nxt = e_if;
                                end
                            end else if (e_v && e_mac == sa_r && e_vl == vl_r) begin
                                fnd_sa_nxt = 1'b1; hit_nxt = rix;
                            end
                        end
                    endcase
                    if (!e_v && !fnd_free_r) begin
                        fnd_free_nxt = 1'b1; free_nxt = rix;
                    end
                end
                if (idx_r == (AW+1)'(DEPTH)) begin
                    st_nxt = ST_DONE;
                end
            end
            ST_DONE: begin
                st_nxt = ST_IDLE;
                case (op_r)
                    OP_FRAME: begin
                        fv_nxt = 1'b1;
                        if (!fnd_da_r) begin
                            ffl_nxt = 1'b1;
                        end else begin
                            ffl_nxt = 1'b0;
                        end
                        if (fnd_sa_r) begin
                            maddr = hit_r;
                            if (!ffl_r) begin
                                // dynamic: refresh and follow the station
                                we = 1'b1;
                                wdata = pack(1'b1, 1'b0, 1'b0, 1'b1, if_r, vl_r, sa_r);
                            end
                            // static hit: never rewritten, moved or relearned
                        end else if (fnd_free_r) begin
                            we = 1'b1; maddr = free_r;
                            wdata = pack(1'b1, 1'b0, 1'b0, 1'b1, if_r, vl_r, sa_r);
                        end
                        if (!fnd_da_r) begin
                            fif_nxt = '0;
                        end
                    end
                    OP_MGMT: begin
                        md_nxt = 1'b1;
                        if (cmd_r == MAT_CMD_ADD_STATIC) begin
                            we = fnd_sa_r || fnd_free_r;
                            maddr = fnd_sa_r ? hit_r : free_r;
                            // interface, MAC and VLAN make the static entry
                            wdata = pack(1'b1, 1'b1, keep_r, 1'b0, if_r, vl_r, sa_r);
                            me_nxt = !(fnd_sa_r || fnd_free_r);
                        end else if (cmd_r == MAT_CMD_DEL_STATIC) begin
                            we = fnd_sa_r; maddr = hit_r;
                            me_nxt = !fnd_sa_r;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            default: begin
                st_nxt = ST_INIT;
            end
        endcase
    end

    // ----------------------------------------
    // state registers
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!resetn) begin
            st_r <= ST_INIT; op_r <= OP_CLEAR; idx_r <= '0;
            free_r <= '0; hit_r <= '0;
            fnd_free_r <= 1'b0; fnd_sa_r <= 1'b0; fnd_da_r <= 1'b0;
            sa_r <= '0; dam_r <= '0; vl_r <= '0; if_r <= '0;
            cmd_r <= 3'h7; qs_r <= 2'h0; keep_r <= 1'b0;
            age_r <= AGE_DEF_S;
            sec_left_r <= AGE_DEF_S; tick_r <= '0; age_req_r <= 1'b0;
            frdy_r <= 1'b0; fv_r <= 1'b0; ffl_r <= 1'b0; fif_r <= '0;
            mrdy_r <= 1'b0; md_r <= 1'b0; me_r <= 1'b0; qv_r <= 1'b0;
            qm_r <= '0; qvl_r <= '0; qif_r <= '0;
        end else begin
            st_r <= st_nxt; op_r <= op_nxt; idx_r <= idx_nxt;
            free_r <= free_nxt; hit_r <= hit_nxt;
            fnd_free_r <= fnd_free_nxt; fnd_sa_r <= fnd_sa_nxt; fnd_da_r <= fnd_da_nxt;
            sa_r <= sa_nxt; dam_r <= dam_nxt; vl_r <= vl_nxt; if_r <= if_nxt;
            cmd_r <= cmd_nxt; qs_r <= qs_nxt; keep_r <= keep_nxt; age_r <= age_nxt;
            sec_left_r <= sec_left_nxt; tick_r <= tick_nxt; age_req_r <= age_req_nxt;
            frdy_r <= frdy_nxt; fv_r <= fv_nxt; ffl_r <= ffl_nxt; fif_r <= fif_nxt;
            mrdy_r <= mrdy_nxt; md_r <= md_nxt; me_r <= me_nxt; qv_r <= qv_nxt;
            qm_r <= qm_nxt; qvl_r <= qvl_nxt; qif_r <= qif_nxt;
        end
    end

    // ----------------------------------------
    // outputs straight from flip-flops
    // ----------------------------------------
    assign frm_ready = frdy_r;
    assign fwd_valid = fv_r;
    assign fwd_flood = ffl_r;
    assign fwd_if = fif_r;
    assign mg_ready = mrdy_r;
    assign mg_done = md_r;
    assign mg_err = me_r;
    assign qr_valid = qv_r;
    assign qr_mac = qm_r;
    assign qr_vlan = qvl_r;
    assign qr_if = qif_r;
    assign age_time = age_r;
endmodule : mat_table
`default_nettype wire

// [tb/mat_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port ingress and management processor
// ----------------------------------------
module mat_host_model
    import mat_pkg::*;
(
    input wire logic clock, // system clock
    input wire logic frm_ready, // header taken
    input wire logic mg_ready, // command taken
    input wire logic mg_done, // command finished
    output logic frm_valid, // header present
    output logic [MAC_W-1:0] frm_sa, // source MAC
    output logic [MAC_W-1:0] frm_da, // destination MAC
    output logic [VLAN_W-1:0] frm_vlan, // VLAN id
    output logic [IF_W-1:0] frm_if, // ingress interface
    output logic mg_valid, // command present
    output logic [2:0] mg_cmd, // command code
    output logic [1:0] mg_qsel, // query filter
    output logic [MAC_W-1:0] mg_mac, // MAC operand
    output logic [VLAN_W-1:0] mg_vlan, // VLAN operand
    output logic [IF_W-1:0] mg_if, // interface operand
    output logic mg_keep, // keep over reset
    output logic [AGE_W-1:0] mg_age // aging time operand
);
    // idle values at time zero
    initial begin
        frm_valid = 1'b0;
        {frm_sa, frm_da, frm_vlan, frm_if} = '0;
        mg_valid = 1'b0;
        {mg_cmd, mg_qsel, mg_mac, mg_vlan, mg_if, mg_keep, mg_age} = '0;
    end
    // present one header and hold it until taken
    task automatic frame(input logic [MAC_W-1:0] sa, input logic [MAC_W-1:0] da,
                         input logic [VLAN_W-1:0] vl, input logic [IF_W-1:0] ifc);
        int n = 0;
        @(posedge clock);
        frm_valid <= 1'b1;
        {frm_sa, frm_da, frm_vlan, frm_if} <= {sa, da, vl, ifc};
        do begin
            @(posedge clock);
            n++;
        end while (frm_ready !== 1'b1 && n < 500);
        frm_valid <= 1'b0;
        {frm_sa, frm_da, frm_vlan, frm_if} <= ~{sa, da, vl, ifc}; // void header
    endtask : frame
    // issue one command, release on take, return once finished
    task automatic mgmt(input logic [2:0] c, input logic [1:0] q, input logic [MAC_W-1:0] m,
                        input logic [VLAN_W-1:0] v, input logic [IF_W-1:0] i, input logic k,
                        input logic [AGE_W-1:0] a);
        int n = 0;
        @(posedge clock);
        mg_valid <= 1'b1;
        {mg_cmd, mg_qsel, mg_mac, mg_vlan, mg_if, mg_keep, mg_age} <= {c, q, m, v, i, k, a};
        do begin
            @(posedge clock);
            if (mg_ready === 1'b1) mg_valid <= 1'b0;
            n++;
        end while (mg_done !== 1'b1 && n < 500);
        {mg_mac, mg_vlan, mg_if, mg_age} <= ~{m, v, i, a}; // void operands
    endtask : mgmt
endmodule : mat_host_model
`default_nettype wire

// [tb/mat_table_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// address table port checks
// ----------------------------------------
module mat_table_asserts
    import mat_pkg::*;
#(
    parameter int DEPTH = 64
) (
    input wire logic clock, // system clock
    input wire logic resetn, // sync reset, active low
    input wire logic frm_ready, // header taken
    input wire logic fwd_valid, // decision pulse
    input wire logic fwd_flood, // flood all ports
    input wire logic [IF_W-1:0] fwd_if, // egress interface
    input wire logic [2:0] mg_cmd, // command code
    input wire logic [AGE_W-1:0] mg_age, // requested aging time
    input wire logic mg_ready, // command taken
    input wire logic mg_done, // command finished
    input wire logic mg_err, // command refused
    input wire logic [AGE_W-1:0] age_time // current aging time
);
    localparam int LAT = DEPTH + 2; // take pulse to answer, one full scan
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    // decisions come exactly one scan after the take pulse
    a_fwd_on_time: assert property (frm_ready |-> ##LAT fwd_valid)
        else $error("forwarding decision late or missing");
    a_flood_no_port: assert property (fwd_valid && fwd_flood |-> fwd_if == '0)
        else $error("flooded decision carries an egress interface");
    a_mg_on_time: assert property (mg_ready && mg_cmd != MAT_CMD_SET_AGE |-> !mg_done ##LAT mg_done)
        else $error("table command finished at the wrong time");
    // aging time is range checked at once
    a_age_answer: assert property (mg_ready && mg_cmd == MAT_CMD_SET_AGE |->
        mg_done && mg_err == (mg_age < AGE_MIN_S || mg_age > AGE_MAX_S))
        else $error("aging time refusal wrong");
    a_err_keeps_age: assert property (mg_done && mg_err |=> $stable(age_time))
        else $error("refused command changed the aging time");
    a_age_in_range: assert property (age_time >= AGE_MIN_S && age_time <= AGE_MAX_S)
        else $error("aging time outside its range");
    a_age_after_reset: assert property ($rose(resetn) |-> age_time == AGE_DEF_S)
        else $error("aging time not at default after reset");
    a_err_with_done: assert property (mg_err |-> mg_done)
        else $error("refusal flag without completion");
endmodule : mat_table_asserts
`default_nettype wire

// [tb/tb_mat_table.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// address table bench
// ----------------------------------------
module tb_mat_table;
    import mat_pkg::*;
    localparam int DEPTH = 16; // short scans
    localparam int SEC = 20; // cycles per simulated second
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic frm_valid, frm_ready, fwd_valid, fwd_flood, mg_valid, mg_keep;
    logic mg_ready, mg_done, mg_err, qr_valid;
    logic [MAC_W-1:0] frm_sa, frm_da, mg_mac, qr_mac, ma, mb, mc, ms, mk, un;
    logic [VLAN_W-1:0] frm_vlan, mg_vlan, qr_vlan;
    logic [IF_W-1:0] frm_if, fwd_if, mg_if, qr_if;
    logic [2:0] mg_cmd;
    logic [1:0] mg_qsel;
    logic [AGE_W-1:0] mg_age, age_time, age_x;
    logic [AGE_W-1:0] ages [4] = '{12'h010, 12'h889, 12'h888, 12'h011};
    logic [IF_W:0] fq[$]; // expected {flood, interface}
    logic [MAC_W+VLAN_W+IF_W-1:0] qq[$]; // expected query rows
    logic eq[$]; // expected refusal flags
    int n_mismatch = 0;
    int n_tests = 0;
    always #25 clock = ~clock;
    mat_table #(.DEPTH(DEPTH), .AW(4), .SEC_CYC(SEC)) DUT (
        .clock(clock), .resetn(resetn), .frm_valid(frm_valid), .frm_sa(frm_sa),
        .frm_da(frm_da), .frm_vlan(frm_vlan), .frm_if(frm_if), .frm_ready(frm_ready),
        .fwd_valid(fwd_valid), .fwd_flood(fwd_flood), .fwd_if(fwd_if), .mg_valid(mg_valid),
        .mg_cmd(mg_cmd), .mg_qsel(mg_qsel), .mg_mac(mg_mac), .mg_vlan(mg_vlan), .mg_if(mg_if),
        .mg_keep(mg_keep), .mg_age(mg_age), .mg_ready(mg_ready), .mg_done(mg_done),
        .mg_err(mg_err), .qr_valid(qr_valid), .qr_mac(qr_mac), .qr_vlan(qr_vlan),
        .qr_if(qr_if), .age_time(age_time));
    mat_host_model u_host (
        .clock(clock), .frm_ready(frm_ready), .mg_ready(mg_ready), .mg_done(mg_done),
        .frm_valid(frm_valid), .frm_sa(frm_sa), .frm_da(frm_da), .frm_vlan(frm_vlan),
        .frm_if(frm_if), .mg_valid(mg_valid), .mg_cmd(mg_cmd), .mg_qsel(mg_qsel),
        .mg_mac(mg_mac), .mg_vlan(mg_vlan), .mg_if(mg_if), .mg_keep(mg_keep), .mg_age(mg_age));
    // ----------------------------------------
    // compare, finish and drive helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [71:0] exp, input logic [71:0] got);
        n_tests++;
        if (exp !== got) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out
    task automatic drain();
        for (int n = 0; n < 400 && fq.size() > 0; n++) @(posedge clock);
    endtask : drain
    task automatic fr(input logic [MAC_W-1:0] sa, input logic [MAC_W-1:0] da,
                      input logic [VLAN_W-1:0] v, input logic [IF_W-1:0] i, input logic fl,
                      input logic [IF_W-1:0] ei);
        fq.push_back({fl, ei});
        u_host.frame(sa, da, v, i);
    endtask : fr
    task automatic mg(input logic [2:0] c, input logic [1:0] q, input logic [MAC_W-1:0] m,
                      input logic [VLAN_W-1:0] v, input logic [IF_W-1:0] i, input logic k,
                      input logic [AGE_W-1:0] a, input logic e);
        drain();
        eq.push_back(e);
        u_host.mgmt(c, q, m, v, i, k, a);
    endtask : mg
    // every result pulse takes the oldest note off its queue
    always @(posedge clock) begin
        if (resetn === 1'b1) begin
            if (fwd_valid === 1'b1)
                check("forwarding", fq.size() > 0 ? fq.pop_front() : 72'hX, {fwd_flood, fwd_if});
            if (qr_valid === 1'b1)
                check("query row", qq.size() > 0 ? qq.pop_front() : 72'hX, {qr_mac, qr_vlan, qr_if});
            if (mg_done === 1'b1)
                check("refusal", eq.size() > 0 ? eq.pop_front() : 72'hX, mg_err);
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'hC4C9));
        ma = {16'h0211, $urandom()};
        mb = {16'h0222, $urandom()};
        mc = {16'h0233, $urandom()};
        ms = {16'h0244, $urandom()};
        mk = {16'h0255, $urandom()};
        un = {16'h0AAA, $urandom()};
        repeat (16) @(posedge clock);
        resetn <= 1'b1;
        repeat (2) @(posedge clock);
        check("aging default", AGE_DEF_S, age_time);
        fr(ma, un, 12'h001, 6'h01, 1'b1, 6'h00);
        fr(mb, ma, 12'h001, 6'h02, 1'b0, 6'h01);
        fr(mc, mb, 12'h007, 6'h04, 1'b1, 6'h00);
        qq.push_back({ma, 12'h001, 6'h01});
        mg(MAT_CMD_QUERY, MAT_QRY_MAC, ma, 12'h000, 6'h00, 1'b0, 12'h000, 1'b0);
        qq.push_back({mb, 12'h001, 6'h02});
        mg(MAT_CMD_QUERY, MAT_QRY_IF, 48'h0, 12'h000, 6'h02, 1'b0, 12'h000, 1'b0);
        qq.push_back({mc, 12'h007, 6'h04});
        mg(MAT_CMD_QUERY, MAT_QRY_VLAN, 48'h0, 12'h007, 6'h00, 1'b0, 12'h000, 1'b0);
        mg(MAT_CMD_ADD_STATIC, 2'h0, ms, 12'h001, 6'h03, 1'b0, 12'h000, 1'b0);
        mg(MAT_CMD_ADD_STATIC, 2'h0, mk, 12'h001, 6'h21, 1'b1, 12'h000, 1'b0);
        fr(ms, mb, 12'h001, 6'h05, 1'b0, 6'h02);
        fr(mb, ms, 12'h001, 6'h02, 1'b0, 6'h03);
        fr(ma, mk, 12'h001, 6'h01, 1'b0, 6'h21);
        mg(MAT_CMD_QUERY, MAT_QRY_IF, 48'h0, 12'h000, 6'h05, 1'b0, 12'h000, 1'b0);
        mg(MAT_CMD_DEL_STATIC, 2'h0, un, 12'h001, 6'h03, 1'b0, 12'h000, 1'b1);
        age_x = AGE_DEF_S;
        foreach (ages[j]) begin
            mg(MAT_CMD_SET_AGE, 2'h0, 48'h0, 12'h000, 6'h00, 1'b0, ages[j], j < 2);
            age_x = (j < 2) ? age_x : ages[j];
            repeat (2) @(posedge clock);
            check("aging time", age_x, age_time);
        end
        fr(un + 48'h1, un, 12'h001, 6'h07, 1'b1, 6'h00);
        repeat (SEC * 17 / 2) @(posedge clock);
        fr(un + 48'h2, un + 48'h1, 12'h001, 6'h08, 1'b0, 6'h07);
        repeat (SEC * 17 * 2 + 4 * DEPTH) @(posedge clock);
        fr(un + 48'h3, un + 48'h1, 12'h001, 6'h09, 1'b1, 6'h00);
        fr(un + 48'h4, ms, 12'h001, 6'h0A, 1'b0, 6'h03);
        drain();
        resetn <= 1'b0;
        repeat (16) @(posedge clock);
        resetn <= 1'b1;
        repeat (2) @(posedge clock);
        check("aging default", AGE_DEF_S, age_time);
        fr(un + 48'h5, mk, 12'h001, 6'h0B, 1'b0, 6'h21);
        fr(un + 48'h6, ms, 12'h001, 6'h0C, 1'b1, 6'h00);
        fr(un + 48'h7, ma, 12'h001, 6'h0D, 1'b1, 6'h00);
        drain();
        close_out();
    end
    // cut a hang short
    initial begin
        repeat (6000) @(posedge clock);
        n_mismatch++;
        close_out();
    end
endmodule : tb_mat_table
bind mat_table mat_table_asserts #(.DEPTH(DEPTH)) u_chk (
    .clock(clock), .resetn(resetn), .frm_ready(frm_ready), .fwd_valid(fwd_valid),
    .fwd_flood(fwd_flood), .fwd_if(fwd_if), .mg_cmd(mg_cmd), .mg_age(mg_age),
    .mg_ready(mg_ready), .mg_done(mg_done), .mg_err(mg_err), .age_time(age_time));
`default_nettype wire
